// ### hdl/motion_fault_code_encoder.sv
// Contract
// RULE_01: Temperature sensor not answering reports code 13.
// RULE_02: Absolute encoder position too large after scaling reports code 16.
// RULE_03: Absolute encoder zero position not found reports code 17.
// RULE_04: CRC failure on absolute encoder data reports code 18.
// RULE_05: Failed absolute encoder position read reports code 19.
// RULE_06: Analog encoder amplitudes too small report code 20.
// RULE_07: Encoder frequency too high to track reports code 21.
// RULE_08: Tracking error above tracking_error_limit reports code 23.
// RULE_09: Velocity above velocity_limit reports code 24.
// RULE_10: Power on with digital_input_one low and config zero reports code 26.
// RULE_11: Motor overtemperature on motor_temp_sense_pin reports code 29.
// RULE_12: Limit switch during movement, config bit 0 set, not homing/search: code 30.
// RULE_13: Sequence label defined twice reports code 33.
// RULE_14: Broken encoder supply fuse reports code 35.
// RULE_15: Jump or call to label above 511 reports code 36.
// RULE_16: Active error code shown in error_code_monitor, 0 to 255, default 0.
// RULE_17: Status word bit 26 set while an error is active.
// RULE_18: Latched code holds until cleared; later faults never overwrite it.
// RULE_19: All faults checked every cycle; code reported one cycle after detection.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module motion_fault_code_encoder (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fault_code_pkg::fault_flags_type flags,
   input wire logic [31:0] encoder_count,
   input wire logic [31:0] tracking_error,
   input wire logic [31:0] velocity,
   input wire logic [15:0] jump_label,
   output logic [7:0] error_code_monitor,
   output logic error_mode,
   output logic irq
);

   // ----------------------------------------------------------------
   // Fault detection
   // ----------------------------------------------------------------
   fault_code_pkg::state_type st_q;
   fault_code_pkg::state_type st_d;
   logic [fault_code_pkg::NUM_FAULTS-1:0] fault_vec;
   logic any_fault;
   logic [7:0] prio_code;
   logic [fault_code_pkg::POS_PRODUCT_W-1:0] pos_product;
   logic [31:0] track_mag;
   logic [31:0] vel_mag;

   assign pos_product = encoder_count * st_q.pos_scale;
   // Sign bit of the signed magnitude read back as unsigned, so -2^31 stays huge
   assign track_mag = tracking_error[31] ? (32'h0000_0000 - tracking_error) : tracking_error;
   assign vel_mag = velocity[31] ? (32'h0000_0000 - velocity) : velocity;

   always_comb begin
      fault_vec = '0;
      fault_vec[fault_code_pkg::IDX_TEMP_SILENT] = flags.temp_sensor_silent; // RULE_01
      fault_vec[fault_code_pkg::IDX_POS_OVERFLOW] =
         |pos_product[fault_code_pkg::POS_PRODUCT_W-1:fault_code_pkg::POS_ALLOWED_MSB+1]; // RULE_02
      fault_vec[fault_code_pkg::IDX_ZERO_MISSING] = flags.zero_pos_missing; // RULE_03
      fault_vec[fault_code_pkg::IDX_CRC] = flags.encoder_crc_error; // RULE_04
      fault_vec[fault_code_pkg::IDX_READ] = flags.encoder_read_error; // RULE_05
      fault_vec[fault_code_pkg::IDX_AMPLITUDE] = flags.analog_amplitude_low; // RULE_06
      fault_vec[fault_code_pkg::IDX_OVERSPEED] = flags.encoder_overspeed; // RULE_07
      fault_vec[fault_code_pkg::IDX_TRACKING] = track_mag > st_q.track_limit; // RULE_08
      fault_vec[fault_code_pkg::IDX_VELOCITY] = vel_mag > st_q.vel_limit; // RULE_09
      fault_vec[fault_code_pkg::IDX_POWER_ON] = flags.power_on_req
         & ~flags.digital_input_one & (st_q.pwr_config == 8'h00); // RULE_10
      fault_vec[fault_code_pkg::IDX_MOTOR_TEMP] = flags.motor_temp_sense_pin; // RULE_11
      fault_vec[fault_code_pkg::IDX_LIMIT_SW] = flags.limit_switch_reached
         & flags.motion_active & st_q.ls_config[fault_code_pkg::LS_STOP_BIT]
         & ~flags.index_homing_cmd & ~flags.limit_switch_search_cmd; // RULE_12
      fault_vec[fault_code_pkg::IDX_LABEL_DUP] = flags.label_redefined; // RULE_13
      fault_vec[fault_code_pkg::IDX_FUSE] = flags.encoder_fuse_broken; // RULE_14
      fault_vec[fault_code_pkg::IDX_LABEL_RANGE] =
         flags.jump_valid & (jump_label > fault_code_pkg::LABEL_MAX); // RULE_15
   end

   fault_priority u_prio (
      .fault_vec(fault_vec),
      .any_fault(any_fault),
      .code(prio_code)
   );

   // ----------------------------------------------------------------
   // Bus write decode
   // ----------------------------------------------------------------
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic clear_req;
   logic ar_take;

   assign aw_take = s_axi_awvalid & st_q.awready;
   assign w_take = s_axi_wvalid & st_q.wready;
   assign wr_fire = (aw_take | st_q.aw_got) & (w_take | st_q.w_got);
   assign wr_addr = st_q.aw_got ? st_q.awaddr : s_axi_awaddr;
   assign wr_data = st_q.w_got ? st_q.wdata : s_axi_wdata;
   assign wr_strb = st_q.w_got ? st_q.wstrb : s_axi_wstrb;
   assign clear_req = wr_fire & (wr_addr == fault_code_pkg::ADDR_CONTROL)
      & wr_strb[0] & wr_data[fault_code_pkg::CTRL_CLEAR_BIT];
   assign ar_take = s_axi_arvalid & st_q.arready;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic [31:0] status_word(input logic err);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[fault_code_pkg::STATUS_ERR_MODE_BIT] = err;
      return w;
   endfunction : status_word

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] tmp;
      logic [1:0] irq_set;
      tmp = 32'h0000_0000;
      irq_set = 2'h0;
      st_d = st_q;

      // Write channel: address and data accepted in either order
      if (aw_take) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = fault_code_pkg::RESP_OKAY;
         case (wr_addr)
            fault_code_pkg::ADDR_CONTROL: begin
            end
            fault_code_pkg::ADDR_TRACK_LIMIT: begin
               st_d.track_limit = merge(st_q.track_limit, wr_data, wr_strb);
            end
            fault_code_pkg::ADDR_VEL_LIMIT: begin
               st_d.vel_limit = merge(st_q.vel_limit, wr_data, wr_strb);
            end
            fault_code_pkg::ADDR_LS_CONFIG: begin
               tmp = merge({24'h00_0000, st_q.ls_config}, wr_data, wr_strb);
               st_d.ls_config = tmp[7:0];
            end
            fault_code_pkg::ADDR_PWR_CONFIG: begin
               tmp = merge({24'h00_0000, st_q.pwr_config}, wr_data, wr_strb);
               st_d.pwr_config = tmp[7:0];
            end
            fault_code_pkg::ADDR_POS_SCALE: begin
               tmp = merge({16'h0000, st_q.pos_scale}, wr_data, wr_strb);
               st_d.pos_scale = tmp[15:0];
            end
            fault_code_pkg::ADDR_ERR_CODE, fault_code_pkg::ADDR_STATUS_WORD: begin
            end
            fault_code_pkg::ADDR_IRQ_STATUS: begin
               if (wr_strb[0]) begin
                  st_d.irq_status = st_q.irq_status & ~wr_data[1:0];
               end
            end
            fault_code_pkg::ADDR_IRQ_MASK: begin
               if (wr_strb[0]) begin
                  st_d.irq_mask = wr_data[1:0];
               end
            end
            default: begin
               st_d.bresp = fault_code_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      // One write at a time: no new address or data until the response is taken
      st_d.awready = ~st_d.aw_got & ~st_d.bvalid;
      st_d.wready = ~st_d.w_got & ~st_d.bvalid;

      // Read channel
      if (ar_take) begin
         st_d.arready = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp = fault_code_pkg::RESP_OKAY;
         case (s_axi_araddr)
            fault_code_pkg::ADDR_CONTROL: st_d.rdata = 32'h0000_0000;
            fault_code_pkg::ADDR_TRACK_LIMIT: st_d.rdata = st_q.track_limit;
            fault_code_pkg::ADDR_VEL_LIMIT: st_d.rdata = st_q.vel_limit;
            fault_code_pkg::ADDR_LS_CONFIG: st_d.rdata = {24'h00_0000, st_q.ls_config};
            fault_code_pkg::ADDR_PWR_CONFIG: st_d.rdata = {24'h00_0000, st_q.pwr_config};
            fault_code_pkg::ADDR_POS_SCALE: st_d.rdata = {16'h0000, st_q.pos_scale};
            fault_code_pkg::ADDR_ERR_CODE: st_d.rdata = {24'h00_0000, st_q.err_code}; // RULE_16
            fault_code_pkg::ADDR_STATUS_WORD: st_d.rdata = status_word(st_q.err_mode); // RULE_17
            fault_code_pkg::ADDR_IRQ_STATUS: st_d.rdata = {30'h0, st_q.irq_status};
            fault_code_pkg::ADDR_IRQ_MASK: st_d.rdata = {30'h0, st_q.irq_mask};
            default: begin
               st_d.rdata = 32'h0000_0000;
               st_d.rresp = fault_code_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end

      // Error latch: clear first, so a fault in the clear cycle is latched anew
      if (clear_req) begin
         st_d.err_mode = 1'b0;
         st_d.err_code = fault_code_pkg::ERR_CODE_RST;
      end
      if (any_fault) begin // RULE_19
         if (!st_d.err_mode) begin // RULE_18
            st_d.err_mode = 1'b1; // RULE_17
            st_d.err_code = prio_code; // RULE_16
            irq_set[fault_code_pkg::IRQ_NEW_ERROR_BIT] = 1'b1;
         end else begin
            irq_set[fault_code_pkg::IRQ_MASKED_FAULT_BIT] = 1'b1;
         end
      end
      // Hardware set wins over a same-cycle write-one clear
      st_d.irq_status = st_d.irq_status | irq_set;
      st_d.irq = |(st_d.irq_status & st_d.irq_mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.track_limit <= fault_code_pkg::TRACK_LIMIT_RST;
         st_q.vel_limit <= fault_code_pkg::VEL_LIMIT_RST;
         st_q.ls_config <= fault_code_pkg::LS_CONFIG_RST;
         st_q.pwr_config <= fault_code_pkg::PWR_CONFIG_RST;
         st_q.pos_scale <= fault_code_pkg::POS_SCALE_RST;
         st_q.err_code <= fault_code_pkg::ERR_CODE_RST;
         st_q.irq_status <= fault_code_pkg::IRQ_RST;
         st_q.irq_mask <= fault_code_pkg::IRQ_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rdata = st_q.rdata;
   assign error_code_monitor = st_q.err_code;
   assign error_mode = st_q.err_mode;
   assign irq = st_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_temp_code: assert property (!st_q.err_mode && flags.temp_sensor_silent
      |=> st_q.err_code == fault_code_pkg::CODE_TEMP_SILENT) // RULE_01
      else $error("temperature sensor fault not coded");
   a_overflow_code: assert property (!st_q.err_mode
      && fault_vec[fault_code_pkg::IDX_POS_OVERFLOW] && !fault_vec[0]
      |=> st_q.err_code == fault_code_pkg::CODE_POS_OVERFLOW) // RULE_02
      else $error("position overflow not coded");
   a_crc_code: assert property (!st_q.err_mode && fault_vec[3:0] == 4'h8
      |=> st_q.err_code == fault_code_pkg::CODE_CRC) // RULE_04
      else $error("encoder crc fault not coded");
   a_tracking_code: assert property (!st_q.err_mode
      && fault_vec == 15'h0080 |=> st_q.err_code == fault_code_pkg::CODE_TRACKING) // RULE_08
      else $error("tracking fault not coded");
   a_velocity_code: assert property (!st_q.err_mode && vel_mag > st_q.vel_limit
      && fault_vec[7:0] == 8'h00 |=> st_q.err_code == fault_code_pkg::CODE_VELOCITY) // RULE_09
      else $error("velocity fault not coded");
   a_power_code: assert property (!st_q.err_mode && fault_vec == 15'h0200
      |=> st_q.err_code == fault_code_pkg::CODE_POWER_ON) // RULE_10
      else $error("power on fault not coded");
   a_limit_exempt: assert property (flags.index_homing_cmd
      |-> !fault_vec[fault_code_pkg::IDX_LIMIT_SW]) // RULE_12
      else $error("limit switch fault during homing");
   a_label_code: assert property (!st_q.err_mode && fault_vec == 15'h4000
      |=> st_q.err_code == fault_code_pkg::CODE_LABEL_RANGE) // RULE_15
      else $error("label range fault not coded");
   a_code_idle: assert property (st_q.err_mode == (st_q.err_code != 8'h00)) // RULE_16
      else $error("error code and error mode disagree");
   a_mode_bit: assert property (st_q.rvalid && $past(ar_take)
      && $past(s_axi_araddr) == fault_code_pkg::ADDR_STATUS_WORD
      |-> st_q.rdata[fault_code_pkg::STATUS_ERR_MODE_BIT] == $past(st_q.err_mode)) // RULE_17
      else $error("status word error bit wrong");
   a_code_hold: assert property (st_q.err_mode && !clear_req |=> $stable(st_q.err_code)) // RULE_18
      else $error("latched error code changed");
   a_one_cycle: assert property (any_fault && (!st_q.err_mode || clear_req)
      |=> st_q.err_mode && st_q.err_code == $past(prio_code)) // RULE_19
      else $error("fault not reported next cycle");

endmodule : motion_fault_code_encoder

`default_nettype wire

// ### hdl/fault_code_pkg.sv
package fault_code_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_FAULTS = 15;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_TRACK_LIMIT = 8'h04;
   localparam logic [7:0] ADDR_VEL_LIMIT = 8'h08;
   localparam logic [7:0] ADDR_LS_CONFIG = 8'h0C;
   localparam logic [7:0] ADDR_PWR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_POS_SCALE = 8'h14;
   localparam logic [7:0] ADDR_ERR_CODE = 8'h18;
   localparam logic [7:0] ADDR_STATUS_WORD = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int LS_STOP_BIT = 0;
   localparam int STATUS_ERR_MODE_BIT = 26;
   localparam int IRQ_NEW_ERROR_BIT = 0;
   localparam int IRQ_MASKED_FAULT_BIT = 1;
   localparam int POS_SCALE_W = 16;
   localparam int POS_PRODUCT_W = 48;
   localparam int POS_ALLOWED_MSB = 30;
   localparam logic [15:0] LABEL_MAX = 16'h01FF;
   localparam logic [31:0] TRACK_LIMIT_RST = 32'h0000_0000;
   localparam logic [31:0] VEL_LIMIT_RST = 32'h0000_0000;
   localparam logic [7:0] LS_CONFIG_RST = 8'h00;
   localparam logic [7:0] PWR_CONFIG_RST = 8'h00;
   localparam logic [15:0] POS_SCALE_RST = 16'h0001;
   localparam logic [7:0] ERR_CODE_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Fault vector positions, lowest code has highest priority
   // ----------------------------------------------------------------
   localparam int IDX_TEMP_SILENT = 0;
   localparam int IDX_POS_OVERFLOW = 1;
   localparam int IDX_ZERO_MISSING = 2;
   localparam int IDX_CRC = 3;
   localparam int IDX_READ = 4;
   localparam int IDX_AMPLITUDE = 5;
   localparam int IDX_OVERSPEED = 6;
   localparam int IDX_TRACKING = 7;
   localparam int IDX_VELOCITY = 8;
   localparam int IDX_POWER_ON = 9;
   localparam int IDX_MOTOR_TEMP = 10;
   localparam int IDX_LIMIT_SW = 11;
   localparam int IDX_LABEL_DUP = 12;
   localparam int IDX_FUSE = 13;
   localparam int IDX_LABEL_RANGE = 14;

   localparam logic [7:0] CODE_TEMP_SILENT = 8'h0D;
   localparam logic [7:0] CODE_POS_OVERFLOW = 8'h10;
   localparam logic [7:0] CODE_ZERO_MISSING = 8'h11;
   localparam logic [7:0] CODE_CRC = 8'h12;
   localparam logic [7:0] CODE_READ = 8'h13;
   localparam logic [7:0] CODE_AMPLITUDE = 8'h14;
   localparam logic [7:0] CODE_OVERSPEED = 8'h15;
   localparam logic [7:0] CODE_TRACKING = 8'h17;
   localparam logic [7:0] CODE_VELOCITY = 8'h18;
   localparam logic [7:0] CODE_POWER_ON = 8'h1A;
   localparam logic [7:0] CODE_MOTOR_TEMP = 8'h1D;
   localparam logic [7:0] CODE_LIMIT_SW = 8'h1E;
   localparam logic [7:0] CODE_LABEL_DUP = 8'h21;
   localparam logic [7:0] CODE_FUSE = 8'h23;
   localparam logic [7:0] CODE_LABEL_RANGE = 8'h24;

   localparam logic [NUM_FAULTS-1:0][7:0] CODE_TABLE = {
      CODE_LABEL_RANGE, CODE_FUSE, CODE_LABEL_DUP, CODE_LIMIT_SW, CODE_MOTOR_TEMP,
      CODE_POWER_ON, CODE_VELOCITY, CODE_TRACKING, CODE_OVERSPEED, CODE_AMPLITUDE,
      CODE_READ, CODE_CRC, CODE_ZERO_MISSING, CODE_POS_OVERFLOW, CODE_TEMP_SILENT};

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic temp_sensor_silent;
      logic zero_pos_missing;
      logic encoder_crc_error;
      logic encoder_read_error;
      logic analog_amplitude_low;
      logic encoder_overspeed;
      logic power_on_req;
      logic digital_input_one;
      logic motor_temp_sense_pin;
      logic limit_switch_reached;
      logic motion_active;
      logic index_homing_cmd;
      logic limit_switch_search_cmd;
      logic label_redefined;
      logic encoder_fuse_broken;
      logic jump_valid;
   } fault_flags_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] track_limit;
      logic [31:0] vel_limit;
      logic [7:0] ls_config;
      logic [7:0] pwr_config;
      logic [15:0] pos_scale;
      logic [7:0] err_code;
      logic err_mode;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic irq;
   } state_type;

endpackage : fault_code_pkg

// ### hdl/fault_priority.sv
`timescale 1ns/1ps
`default_nettype none

module fault_priority (
   input wire logic [fault_code_pkg::NUM_FAULTS-1:0] fault_vec,
   output logic any_fault,
   output logic [7:0] code
);

   logic [fault_code_pkg::NUM_FAULTS:0] taken;
   logic [fault_code_pkg::NUM_FAULTS:0][7:0] acc;

   assign taken[0] = 1'b0;
   assign acc[0] = 8'h00;

   // Lowest code wins when several faults rise together
   for (genvar i = 0; i < fault_code_pkg::NUM_FAULTS; i++) begin : g_prio
      logic sel;
      assign sel = fault_vec[i] & ~taken[i];
      assign taken[i+1] = taken[i] | fault_vec[i];
      assign acc[i+1] = acc[i] | ({8{sel}} & fault_code_pkg::CODE_TABLE[i]);
   end

   assign any_fault = taken[fault_code_pkg::NUM_FAULTS];
   assign code = acc[fault_code_pkg::NUM_FAULTS];

endmodule : fault_priority

`default_nettype wire

// ### test/fault_source.sv
`timescale 1ns/1ps
`default_nettype none

module fault_source (
   input wire logic [4:0] sel,
   output fault_code_pkg::fault_flags_type flags,
   output logic [31:0] encoder_count,
   output logic [31:0] tracking_error,
   output logic [31:0] velocity,
   output logic [15:0] jump_label
);
   // Quiet state sits on the boundaries: widest legal count, label 511
   always_comb begin
      flags = '0;
      flags.digital_input_one = 1'h1;
      flags.jump_valid = 1'h1;
      encoder_count = 32'h7FFF_FFFF;
      tracking_error = 32'h0000_0000;
      velocity = 32'h0000_0000;
      jump_label = 16'h01FF;
      case (sel)
         5'h00: flags.temp_sensor_silent = 1'h1;
         5'h01: encoder_count = 32'h8000_0000;
         5'h02: flags.zero_pos_missing = 1'h1;
         5'h03: flags.encoder_crc_error = 1'h1;
         5'h04: flags.encoder_read_error = 1'h1;
         5'h05: flags.analog_amplitude_low = 1'h1;
         5'h06: flags.encoder_overspeed = 1'h1;
         5'h07: tracking_error = 32'h0000_0001;
         5'h08: velocity = 32'h0000_0001;
         5'h09: {flags.power_on_req, flags.digital_input_one} = 2'h2;
         5'h0A: flags.motor_temp_sense_pin = 1'h1;
         5'h0B: {flags.limit_switch_reached, flags.motion_active} = 2'h3;
         5'h0C: flags.label_redefined = 1'h1;
         5'h0D: flags.encoder_fuse_broken = 1'h1;
         5'h0E: jump_label = 16'h0200;
         5'h0F: {flags.limit_switch_reached, flags.motion_active, flags.index_homing_cmd} = 3'h7;
         5'h10: {flags.limit_switch_reached, flags.motion_active,
                 flags.limit_switch_search_cmd} = 3'h7;
         default: ;
      endcase
   end
endmodule : fault_source

`default_nettype wire

// ### test/tb_motion_fault_code_encoder.sv
`timescale 1ns/1ps
`default_nettype none

module tb_motion_fault_code_encoder;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, irq, mode;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, code;
   logic [31:0] wdata = 32'h0, rdata, enc, trk, vel, d;
   logic [1:0] bresp, rresp, r;
   logic [4:0] sel = 5'h1F;
   logic [15:0] lbl;
   fault_code_pkg::fault_flags_type flags;
   int num_errors = 0, compares = 0, cycles = 0;
   always #50 aclk = ~aclk;
   fault_source src (.sel(sel), .flags(flags), .encoder_count(enc), .tracking_error(trk),
      .velocity(vel), .jump_label(lbl));
   motion_fault_code_encoder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .flags(flags), .encoder_count(enc), .tracking_error(trk),
      .velocity(vel), .jump_label(lbl), .error_code_monitor(code), .error_mode(mode), .irq(irq));
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic done;
      done = 1'h0;
      @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            bready <= 1'h0;
            {done, r} = {1'h1, bresp};
         end
      end
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic done;
      done = 1'h0;
      @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'h3};
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            rready <= 1'h0;
            {done, v, rs} = {1'h1, rdata, rresp};
         end
      end
   endtask : rd
   task wait2(input logic [4:0] s);
      @(posedge aclk) sel <= s;
      repeat (2) @(posedge aclk);
   endtask : wait2
   task stop_test;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge aclk) if (++cycles == 5000) begin
      num_errors++;
      stop_test;
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task fault_case(input logic [4:0] s, input logic [7:0] c);
      wait2(s);
      chk("code", code, c);
      chk("mode", mode, 1'h1);
      sel <= 5'h1F;
      wr(fault_code_pkg::ADDR_CONTROL, 32'h1);
      chk("cleared", code, 8'h00);
   endtask : fault_case
   task t_reset;
      rd(fault_code_pkg::ADDR_ERR_CODE, d, r);
      chk("monitor", d, 32'h0);
      rd(8'h40, d, r);
      chk("unmapped rd", d, 32'h0);
      chk("rresp", {30'h0, r}, 32'h2);
      wr(8'h40, 32'h1);
      chk("bresp", {30'h0, r}, 32'h2);
      wr(fault_code_pkg::ADDR_LS_CONFIG, 32'h1);
      $display("test reset done");
   endtask : t_reset
   task t_latch_irq;
      wr(fault_code_pkg::ADDR_IRQ_STATUS, 32'h3);
      wr(fault_code_pkg::ADDR_IRQ_MASK, 32'h1);
      chk("irq idle", irq, 1'h0);
      wait2(5'h0E);
      wait2(5'h00);
      chk("latched", code, 8'h24);
      chk("irq", irq, 1'h1);
      rd(fault_code_pkg::ADDR_STATUS_WORD, d, r);
      chk("status word", d, 32'h1 << fault_code_pkg::STATUS_ERR_MODE_BIT);
      rd(fault_code_pkg::ADDR_IRQ_STATUS, d, r);
      chk("irq status", d, 32'h3);
      sel <= 5'h1F;
      wr(fault_code_pkg::ADDR_CONTROL, 32'h1);
      wr(fault_code_pkg::ADDR_IRQ_STATUS, 32'h3);
      chk("irq cleared", {irq, code}, 9'h000);
      $display("test latch done");
   endtask : t_latch_irq
   task t_except;
      wait2(5'h0F);
      wait2(5'h10);
      chk("no fault", code, 8'h00);
      wr(fault_code_pkg::ADDR_POS_SCALE, 32'h2);
      wait2(5'h1F);
      chk("scaled", code, 8'h10);
      $display("test except done");
   endtask : t_except
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      fault_case(5'h00, 8'h0D);
      fault_case(5'h01, 8'h10);
      fault_case(5'h02, 8'h11);
      fault_case(5'h03, 8'h12);
      fault_case(5'h04, 8'h13);
      fault_case(5'h05, 8'h14);
      fault_case(5'h06, 8'h15);
      fault_case(5'h07, 8'h17);
      fault_case(5'h08, 8'h18);
      fault_case(5'h09, 8'h1A);
      fault_case(5'h0A, 8'h1D);
      fault_case(5'h0B, 8'h1E);
      fault_case(5'h0C, 8'h21);
      fault_case(5'h0D, 8'h23);
      fault_case(5'h0E, 8'h24);
      $display("test codes done");
      t_latch_irq;
      t_except;
      stop_test;
   end
endmodule : tb_motion_fault_code_encoder

`default_nettype wire
